// file: pkg/migp_map.svh
/*
  Constants for the mode-indexed GPIO ports: data file addresses, config-select
  codes, reset values and comparator field positions.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef MIGP_MAP_SVH
`define MIGP_MAP_SVH

`define MIGP_ADDR_PORT_A   5'h05
`define MIGP_ADDR_PORT_B   5'h06
`define MIGP_ADDR_PORT_C   5'h07

`define MIGP_SEL_CMP       8'h08
`define MIGP_SEL_FLAGS     8'h09
`define MIGP_SEL_EDGE      8'h0a
`define MIGP_SEL_WAKE      8'h0b
`define MIGP_SEL_HYST      8'h0c
`define MIGP_SEL_LEVEL     8'h0d
`define MIGP_SEL_PULLUP    8'h0e
`define MIGP_SEL_DIR       8'h0f

`define MIGP_SEL_RESET     8'h0f
`define MIGP_CFG_RESET     8'hff
`define MIGP_CMP_RESET     8'hff

`define MIGP_CMP_EN_BIT    7
`define MIGP_CMP_OUT_BIT   6
`define MIGP_CMP_RES_BIT   0

`define MIGP_PORT_A_WIDTH  4

`endif

// file: pkg/migp_pkg.sv
/*
  Types shared by the mode-indexed GPIO ports.
  Assumes migp_map.svh is on the include path.
*/
`default_nettype none
`include "migp_map.svh"

package migp_pkg;
  typedef enum logic [1:0] {
    MIGP_PORT_A    = 2'b00,
    MIGP_PORT_B    = 2'b01,
    MIGP_PORT_C    = 2'b10,
    MIGP_PORT_NONE = 2'b11
  } migp_port_t;
endpackage

`default_nettype wire

// file: verilog/migp_pin_sync.sv
/*
  Two flip-flop synchroniser for a bus of pin levels.
  Assumes asynchronous pins and one ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module migp_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_r <= '0;
      pin_sync <= '0;
    end else begin
      stage1_r <= pin_async;
      pin_sync <= stage1_r;
    end
  end
endmodule

`default_nettype wire

// file: verilog/migp_gpio.sv
/*
  Three GPIO ports (A 4-bit, B and C 8-bit) with data registers in the file
  space, a config-select register and config registers reached by a
  port-control write. Port B wake flags and comparator control swap with W.
  Assumes the CPU core gives single-cycle file reads/writes, config-select
  access strobes and a port-control write strobe; analog parts sit outside.
*/
`timescale 1ns/1ps
`default_nettype none

`include "migp_map.svh"

// What this block does
// - Data registers at file addresses 05h-07h
// - Data write drives pins set as output
// - Port A uses low four bits only
// - Input-pin writes still update the latch
// - Data reads return synchronised pin levels
// - Externally held pins read their real level
// - Config-select picks port-control write target
// - Config-select loaded from literal/W, readable
// - Config-select resets to 0Fh
// - Config-select persists until rewritten
// - Direction bit: 1 input, 0 output
// - Pullup bit: 1 off, 0 on
// - Level bit: 1 TTL, 0 CMOS unless hysteresis
// - Hysteresis bit B/C: 0 on, 1 off
// - Wake-disable bit: 0 enables port B wakeup
// - Wake edge: 0 rising, 1 falling
// - Select 09h swaps W with wake flags
// - Wake flag set on selected enabled edge
// - Select 08h swaps W with comparator control
// - Config registers reset to all ones, wake flags to zero
module migp_gpio
  import migp_pkg::*;
#(
  parameter int PA_W = `MIGP_PORT_A_WIDTH,
  parameter int PB_W = 8,
  parameter int PC_W = 8
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire logic [4:0]      file_addr,
  input  wire logic            file_wr,
  input  wire logic [7:0]      file_wdata,
  output logic      [7:0]      file_rdata,
  output logic                 file_hit,
  input  wire logic            sel_wr,
  input  wire logic [7:0]      sel_wdata,
  output logic      [7:0]      sel_rdata,
  input  wire logic            pctl_wr,
  input  wire migp_port_t      pctl_port,
  input  wire logic [7:0]      w_in,
  output logic                 w_load,
  output logic      [7:0]      w_swap_data,
  input  wire logic            cmp_result,
  input  wire logic [PA_W-1:0] pa_in,
  output logic      [PA_W-1:0] pa_out,
  output logic      [PA_W-1:0] pa_oe,
  output logic      [PA_W-1:0] pa_pullup_en,
  output logic      [PA_W-1:0] pa_ttl_sel,
  input  wire logic [PB_W-1:0] pb_in,
  output logic      [PB_W-1:0] pb_out,
  output logic      [PB_W-1:0] pb_oe,
  output logic      [PB_W-1:0] pb_pullup_en,
  output logic      [PB_W-1:0] pb_ttl_sel,
  output logic      [PB_W-1:0] pb_schmitt_en,
  output logic      [PB_W-1:0] pb_wake_en,
  output logic      [PB_W-1:0] pb_wake_flags_o,
  input  wire logic [PC_W-1:0] pc_in,
  output logic      [PC_W-1:0] pc_out,
  output logic      [PC_W-1:0] pc_oe,
  output logic      [PC_W-1:0] pc_pullup_en,
  output logic      [PC_W-1:0] pc_ttl_sel,
  output logic      [PC_W-1:0] pc_schmitt_en,
  output logic                 cmp_enable,
  output logic                 cmp_pin_out_en
);

  logic [7:0]      config_select_r;
  logic [PA_W-1:0] port_a_data_r, port_a_direction_r, port_a_pullup_off_r, port_a_input_level_r;
  logic [PB_W-1:0] port_b_data_r, port_b_direction_r, port_b_pullup_off_r, port_b_input_level_r;
  logic [PC_W-1:0] port_c_data_r, port_c_direction_r, port_c_pullup_off_r, port_c_input_level_r;
  logic [PB_W-1:0] port_b_hysteresis_off_r, port_b_wake_disable_r, port_b_wake_falling_r;
  logic [PC_W-1:0] port_c_hysteresis_off_r;
  logic [PB_W-1:0] port_b_wake_flags_r, port_b_wake_flags_nxt;
  logic [7:0]      comparator_control_r;
  logic [PA_W-1:0] pa_sync;
  logic [PB_W-1:0] pb_sync;
  logic [PC_W-1:0] pc_sync;
  logic [PB_W-1:0] pb_prev_r;
  logic [PB_W-1:0] pb_edge;
  logic            cmp_sync;
  logic            wr_a, wr_b, wr_c;
  logic            swap_flags, swap_cmp;

  // Pins are asynchronous to ref_clk
  migp_pin_sync #(.W(PA_W)) u_sync_a (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (pa_in),
    .pin_sync  (pa_sync)
  );

  migp_pin_sync #(.W(PB_W)) u_sync_b (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (pb_in),
    .pin_sync  (pb_sync)
  );

  migp_pin_sync #(.W(PC_W)) u_sync_c (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (pc_in),
    .pin_sync  (pc_sync)
  );

  migp_pin_sync #(.W(1)) u_sync_cmp (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (cmp_result),
    .pin_sync  (cmp_sync)
  );

  assign wr_a = pctl_wr && (pctl_port == MIGP_PORT_A);
  assign wr_b = pctl_wr && (pctl_port == MIGP_PORT_B);
  assign wr_c = pctl_wr && (pctl_port == MIGP_PORT_C);
  assign swap_flags = wr_b && (config_select_r == `MIGP_SEL_FLAGS);
  assign swap_cmp   = wr_b && (config_select_r == `MIGP_SEL_CMP);

  // Config-select register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      config_select_r <= `MIGP_SEL_RESET;
    end else if (sel_wr) begin
      config_select_r <= sel_wdata;
    end
  end

  assign sel_rdata = config_select_r;

  // Data latches; written regardless of direction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_data_r <= '1;
      port_b_data_r <= '1;
      port_c_data_r <= '1;
    end else if (file_wr) begin
      case (file_addr)
        `MIGP_ADDR_PORT_A: port_a_data_r <= file_wdata[PA_W-1:0];
        `MIGP_ADDR_PORT_B: port_b_data_r <= file_wdata[PB_W-1:0];
        `MIGP_ADDR_PORT_C: port_c_data_r <= file_wdata[PC_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Reads sample pins, not latches
  always_comb begin
    file_rdata = 8'h00;
    file_hit   = 1'b1;
    case (file_addr)
      `MIGP_ADDR_PORT_A: file_rdata[PA_W-1:0] = pa_sync;
      `MIGP_ADDR_PORT_B: file_rdata[PB_W-1:0] = pb_sync;
      `MIGP_ADDR_PORT_C: file_rdata[PC_W-1:0] = pc_sync;
      default:           file_hit = 1'b0;
    endcase
  end

  // Port-control writes, steered by config-select
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_direction_r   <= '1;
      port_a_pullup_off_r  <= '1;
      port_a_input_level_r <= '1;
    end else if (wr_a) begin
      case (config_select_r)
        `MIGP_SEL_DIR:    port_a_direction_r   <= w_in[PA_W-1:0];
        `MIGP_SEL_PULLUP: port_a_pullup_off_r  <= w_in[PA_W-1:0];
        `MIGP_SEL_LEVEL:  port_a_input_level_r <= w_in[PA_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_b_direction_r      <= '1;
      port_b_pullup_off_r     <= '1;
      port_b_input_level_r    <= '1;
      port_b_hysteresis_off_r <= '1;
      port_b_wake_disable_r   <= '1;
      port_b_wake_falling_r   <= '1;
    end else if (wr_b) begin
      case (config_select_r)
        `MIGP_SEL_DIR:    port_b_direction_r      <= w_in[PB_W-1:0];
        `MIGP_SEL_PULLUP: port_b_pullup_off_r     <= w_in[PB_W-1:0];
        `MIGP_SEL_LEVEL:  port_b_input_level_r    <= w_in[PB_W-1:0];
        `MIGP_SEL_HYST:   port_b_hysteresis_off_r <= w_in[PB_W-1:0];
        `MIGP_SEL_WAKE:   port_b_wake_disable_r   <= w_in[PB_W-1:0];
        `MIGP_SEL_EDGE:   port_b_wake_falling_r   <= w_in[PB_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_c_direction_r      <= '1;
      port_c_pullup_off_r     <= '1;
      port_c_input_level_r    <= '1;
      port_c_hysteresis_off_r <= '1;
    end else if (wr_c) begin
      case (config_select_r)
        `MIGP_SEL_DIR:    port_c_direction_r      <= w_in[PC_W-1:0];
        `MIGP_SEL_PULLUP: port_c_pullup_off_r     <= w_in[PC_W-1:0];
        `MIGP_SEL_LEVEL:  port_c_input_level_r    <= w_in[PC_W-1:0];
        `MIGP_SEL_HYST:   port_c_hysteresis_off_r <= w_in[PC_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Wake edge detect on synchronised port B levels
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pb_prev_r <= '0;
    end else begin
      pb_prev_r <= pb_sync;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PB_W; gi++) begin : g_wake
      assign pb_edge[gi] = !port_b_wake_disable_r[gi] &&
                           (port_b_wake_falling_r[gi] ? (pb_prev_r[gi] && !pb_sync[gi])
                                                      : (!pb_prev_r[gi] && pb_sync[gi]));
    end
  endgenerate

  // Edge in the swap cycle survives: set wins over the swap-in
  always_comb begin
    port_b_wake_flags_nxt = port_b_wake_flags_r;
    if (swap_flags) begin
      port_b_wake_flags_nxt = w_in[PB_W-1:0];
    end
    port_b_wake_flags_nxt = port_b_wake_flags_nxt | pb_edge;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_b_wake_flags_r <= '0;
    end else begin
      port_b_wake_flags_r <= port_b_wake_flags_nxt;
    end
  end

  // Comparator control; result bit follows the analog comparator
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      comparator_control_r <= `MIGP_CMP_RESET;
    end else if (swap_cmp) begin
      comparator_control_r <= w_in;
    end else begin
      comparator_control_r[`MIGP_CMP_RES_BIT] <= cmp_sync;
    end
  end

  // Old contents handed back to W; other writes leave W alone
  always_comb begin
    w_load      = swap_flags || swap_cmp;
    w_swap_data = 8'h00;
    if (swap_flags) begin
      w_swap_data[PB_W-1:0] = port_b_wake_flags_r;
    end else if (swap_cmp) begin
      w_swap_data = comparator_control_r;
    end
  end

  // Pin drive: latch value shows only where direction is output
  assign pa_out = port_a_data_r;
  assign pb_out = port_b_data_r;
  assign pc_out = port_c_data_r;
  assign pa_oe  = ~port_a_direction_r;
  assign pb_oe  = ~port_b_direction_r;
  assign pc_oe  = ~port_c_direction_r;

  assign pa_pullup_en = ~port_a_pullup_off_r;
  assign pb_pullup_en = ~port_b_pullup_off_r;
  assign pc_pullup_en = ~port_c_pullup_off_r;

  // Level select only matters with hysteresis off; port A has none
  assign pa_ttl_sel    = port_a_input_level_r;
  assign pb_ttl_sel    = port_b_input_level_r & port_b_hysteresis_off_r;
  assign pc_ttl_sel    = port_c_input_level_r & port_c_hysteresis_off_r;
  assign pb_schmitt_en = ~port_b_hysteresis_off_r;
  assign pc_schmitt_en = ~port_c_hysteresis_off_r;

  assign pb_wake_en      = ~port_b_wake_disable_r;
  assign pb_wake_flags_o = port_b_wake_flags_r;
  assign cmp_enable      = !comparator_control_r[`MIGP_CMP_EN_BIT];
  assign cmp_pin_out_en  = !comparator_control_r[`MIGP_CMP_OUT_BIT];

endmodule

`default_nettype wire

// file: testbench/migp_gpio_asserts.sv
/*
  Checker bound into migp_gpio.
  Assumes it sees the design ports only, all on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module migp_gpio_asserts
  import migp_pkg::*;
#(
  parameter int PA_W = 4
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire logic [4:0]      file_addr,
  input  wire logic            file_wr,
  input  wire logic [7:0]      file_wdata,
  input  wire logic            file_hit,
  input  wire logic            sel_wr,
  input  wire logic [7:0]      sel_wdata,
  input  wire logic [7:0]      sel_rdata,
  input  wire logic            pctl_wr,
  input  wire migp_port_t      pctl_port,
  input  wire logic [7:0]      w_in,
  input  wire logic            w_load,
  input  wire logic [7:0]      w_swap_data,
  input  wire logic [PA_W-1:0] pa_pullup_en,
  input  wire logic [7:0]      pb_out,
  input  wire logic [7:0]      pb_oe,
  input  wire logic [7:0]      pb_wake_flags_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Port-control strobe under one config-select code
  sequence s_pctl(migp_port_t p, logic [7:0] code);
    pctl_wr && pctl_port == p && sel_rdata == code;
  endsequence

  a_sel_load: assert property (sel_wr |=> sel_rdata == $past(sel_wdata))
    else $error("config select not loaded");
  a_data_write: assert property (file_wr && file_addr == 5'h06 |=> pb_out == $past(file_wdata))
    else $error("port b latch not written");
  a_hit_decode: assert property (file_hit == (file_addr >= 5'h05 && file_addr <= 5'h07))
    else $error("file hit decode wrong");
  a_dir_write: assert property (s_pctl(MIGP_PORT_B, 8'h0f) |=> pb_oe == ~$past(w_in))
    else $error("port b direction not written");
  a_pullup_write: assert property (s_pctl(MIGP_PORT_A, 8'h0e) |=> pa_pullup_en == PA_W'(~$past(w_in)))
    else $error("port a pullup not written");
  a_swap_load: assert property (w_load == (pctl_wr && pctl_port == MIGP_PORT_B &&
    (sel_rdata == 8'h08 || sel_rdata == 8'h09)))
    else $error("w load wrong");
  a_wake_swap: assert property (s_pctl(MIGP_PORT_B, 8'h09) |-> w_swap_data == pb_wake_flags_o)
    else $error("wake flags not swapped out");
  // Codes 00h-0Bh hold nothing for ports A and C, nor for no port
  a_unmapped_idle: assert property (pctl_wr && pctl_port != MIGP_PORT_B && sel_rdata < 8'h0c
    |=> $stable(pb_oe) && $stable(pa_pullup_en))
    else $error("unmapped port control changed state");
endmodule

bind migp_gpio migp_gpio_asserts #(.PA_W(PA_W)) migp_gpio_asserts_inst (.ref_clk, .rstn, .file_addr,
  .file_wr, .file_wdata, .file_hit, .sel_wr, .sel_wdata, .sel_rdata, .pctl_wr, .pctl_port, .w_in,
  .w_load, .w_swap_data, .pa_pullup_en, .pb_out, .pb_oe, .pb_wake_flags_o);

`default_nettype wire

// file: testbench/migp_pins.sv
/*
  Outside circuits on ports A, B and C.
  Assumes the latch, enable and pullup outputs of migp_gpio.
*/
`timescale 1ns/1ps
`default_nettype none

module migp_pins (
  input  wire logic [3:0] pa_out,
  input  wire logic [3:0] pa_oe,
  input  wire logic [3:0] pa_pullup_en,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pb_pullup_en,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe,
  input  wire logic [7:0] pc_pullup_en,
  input  wire logic [7:0] ext_en_b,
  input  wire logic [7:0] ext_val_b,
  input  wire logic [7:0] ext_en_c,
  input  wire logic [7:0] ext_val_c,
  output logic      [3:0] pa_in,
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in
);
  // Outside source wins; a floating pin reads high with its pullup on,
  // otherwise it shows the inverse of the latch, so a stale value never reads as a match
  function automatic logic [7:0] lvl(input logic [7:0] d, oe, pu, en, v);
    return (en & v) | (~en & oe & d) | (~en & ~oe & (pu | ~d));
  endfunction

  logic [7:0] pa_full;
  assign pa_full = lvl({4'h0, pa_out}, {4'h0, pa_oe}, {4'h0, pa_pullup_en}, 8'h00, 8'h00);
  assign pa_in   = pa_full[3:0];
  assign pb_in   = lvl(pb_out, pb_oe, pb_pullup_en, ext_en_b, ext_val_b);
  assign pc_in   = lvl(pc_out, pc_oe, pc_pullup_en, ext_en_c, ext_val_c);
endmodule

`default_nettype wire

// file: testbench/mode_indexed_gpio_ports_bench.sv
/*
  Self-checking bench for migp_gpio with the pin model.
  Assumes the checker and pin model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %0t: got %h exp %h", $time, g, e); end end

module mode_indexed_gpio_ports_bench;
  import migp_pkg::*;
  logic       ref_clk, rstn, file_wr, file_hit, sel_wr, pctl_wr, w_load, cmp_result, cmp_enable, cmp_pin_out_en;
  logic [4:0] file_addr;
  logic [7:0] file_wdata, file_rdata, sel_wdata, sel_rdata, w_in, w_swap_data;
  logic [3:0] pa_in, pa_out, pa_oe, pa_pullup_en, pa_ttl_sel;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_ttl_sel, pb_schmitt_en, pb_wake_en, pb_wake_flags_o;
  logic [7:0] pc_in, pc_out, pc_oe, pc_pullup_en, pc_ttl_sel, pc_schmitt_en;
  logic [7:0] ext_en_b, ext_val_b, ext_en_c, ext_val_c;
  migp_port_t pctl_port;
  int         error_cnt, n_checks, cyc;

  migp_gpio migp_gpio_inst (.ref_clk, .rstn, .file_addr, .file_wr, .file_wdata, .file_rdata, .file_hit,
    .sel_wr, .sel_wdata, .sel_rdata, .pctl_wr, .pctl_port, .w_in, .w_load, .w_swap_data, .cmp_result,
    .pa_in, .pa_out, .pa_oe, .pa_pullup_en, .pa_ttl_sel, .pb_in, .pb_out, .pb_oe, .pb_pullup_en,
    .pb_ttl_sel, .pb_schmitt_en, .pb_wake_en, .pb_wake_flags_o, .pc_in, .pc_out, .pc_oe, .pc_pullup_en,
    .pc_ttl_sel, .pc_schmitt_en, .cmp_enable, .cmp_pin_out_en);
  migp_pins migp_pins_inst (.pa_out, .pa_oe, .pa_pullup_en, .pb_out, .pb_oe, .pb_pullup_en, .pc_out,
    .pc_oe, .pc_pullup_en, .ext_en_b, .ext_val_b, .ext_en_c, .ext_val_c, .pa_in, .pb_in, .pc_in);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  // Idle cycle after each write keeps same-port updates apart
  task automatic fwr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {file_addr, file_wdata, file_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    file_wr = 1'b0;
  endtask

  // Pin levels pass a two-flop synchroniser before they read back
  task automatic frd(input logic [4:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    file_addr = a;
    repeat (3) @(negedge ref_clk);
    `CHK(file_rdata, e)
  endtask

  task automatic selw(input logic [7:0] v);
    @(negedge ref_clk);
    {sel_wdata, sel_wr} = {v, 1'b1};
    @(negedge ref_clk);
    sel_wr = 1'b0;
  endtask

  task automatic pctl(input migp_port_t p, input logic [7:0] w, input logic ld, input logic [7:0] sw);
    @(negedge ref_clk);
    {pctl_port, w_in, pctl_wr} = {p, w, 1'b1};
    #1;
    `CHK({w_load, w_swap_data}, {ld, sw})
    @(negedge ref_clk);
    pctl_wr = 1'b0;
  endtask

  task automatic rst();
    rstn = 1'b0;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    `CHK({sel_rdata, pb_oe, pb_ttl_sel, pb_wake_en, pb_wake_flags_o, pc_pullup_en}, 48'h0f00ff000000)
  endtask

  initial begin
    {file_wr, sel_wr, pctl_wr, file_addr, file_wdata, sel_wdata, w_in} = '0;
    {ext_en_b, ext_val_b, ext_en_c, ext_val_c} = '0;
    pctl_port = MIGP_PORT_NONE;
    cmp_result = 1'b1;
    rst();
    frd(5'h05, 8'h00);
    fwr(5'h06, 8'ha5);
    `CHK({pb_out, pb_oe}, 16'ha500)
    pctl(MIGP_PORT_B, 8'h00, 1'b0, 8'h00);
    frd(5'h06, 8'ha5);
    ext_en_b = 8'h01;
    frd(5'h06, 8'ha4);
    fwr(5'h05, 8'hff);
    pctl(MIGP_PORT_A, 8'h00, 1'b0, 8'h00);
    frd(5'h05, 8'h0f);
    {ext_en_c, ext_val_c} = 16'hff3c;
    frd(5'h07, 8'h3c);
    fwr(5'h08, 8'h00);
    `CHK({file_hit, file_rdata, pc_out}, 17'h000ff)
    $display("test data finished");
    selw(8'h0e);
    pctl(MIGP_PORT_A, 8'h03, 1'b0, 8'h00);
    pctl(MIGP_PORT_B, 8'hff, 1'b0, 8'h00);
    pctl(MIGP_PORT_C, 8'h00, 1'b0, 8'h00);
    `CHK({pa_pullup_en, pb_pullup_en, pc_pullup_en, sel_rdata}, 28'hc00ff0e)
    selw(8'h0d);
    pctl(MIGP_PORT_C, 8'h0f, 1'b0, 8'h00);
    pctl(MIGP_PORT_A, 8'h05, 1'b0, 8'h00);
    pctl(MIGP_PORT_B, 8'h3c, 1'b0, 8'h00);
    `CHK({pc_ttl_sel, pa_ttl_sel, pb_ttl_sel}, 20'h0f53c)
    selw(8'h0c);
    pctl(MIGP_PORT_C, 8'hf0, 1'b0, 8'h00);
    pctl(MIGP_PORT_B, 8'h0f, 1'b0, 8'h00);
    pctl(MIGP_PORT_A, 8'h00, 1'b0, 8'h00);
    `CHK({pc_schmitt_en, pc_ttl_sel, pa_ttl_sel}, 20'h0f005)
    `CHK({pb_schmitt_en, pb_ttl_sel}, 16'hf00c)
    $display("test config finished");
    selw(8'h0a);
    pctl(MIGP_PORT_B, 8'h00, 1'b0, 8'h00);
    selw(8'h0b);
    pctl(MIGP_PORT_B, 8'hfe, 1'b0, 8'h00);
    `CHK({pb_wake_en, pb_wake_flags_o}, 16'h0100)
    ext_val_b = 8'h01;
    repeat (5) @(negedge ref_clk);
    `CHK(pb_wake_flags_o, 8'h01)
    selw(8'h09);
    pctl(MIGP_PORT_B, 8'h00, 1'b1, 8'h01);
    `CHK(pb_wake_flags_o, 8'h00)
    selw(8'h0a);
    pctl(MIGP_PORT_B, 8'hff, 1'b0, 8'h00);
    ext_val_b = 8'h00;
    repeat (5) @(negedge ref_clk);
    `CHK(pb_wake_flags_o, 8'h01)
    $display("test wake finished");
    selw(8'h08);
    // Result bit swapped in high must come back as the live low result
    pctl(MIGP_PORT_B, 8'h3f, 1'b1, 8'hff);
    `CHK({cmp_enable, cmp_pin_out_en}, 2'b11)
    cmp_result = 1'b0;
    repeat (3) @(negedge ref_clk);
    pctl(MIGP_PORT_B, 8'hc1, 1'b1, 8'h3e);
    `CHK({cmp_enable, cmp_pin_out_en}, 2'b00)
    // Legal code with no register behind ports A and C
    selw(8'h0b);
    pctl(MIGP_PORT_A, 8'h0f, 1'b0, 8'h00);
    pctl(MIGP_PORT_C, 8'h00, 1'b0, 8'h00);
    pctl(MIGP_PORT_NONE, 8'h00, 1'b0, 8'h00);
    `CHK({pb_oe, pa_oe, pc_oe, pb_wake_en, sel_rdata}, 36'hfff00010b)
    rst();
    $display("test swap finished");
    final_report();
  end
endmodule

`default_nettype wire
